// ### inc/codec_ctl_pkg.sv
// Constants and types for the paged two-wire control slave.
// Assumes a 125 MHz system clock; the bus lines are asynchronous pins.
package codec_ctl_pkg;
    localparam logic [4:0] ADDR_FIXED_HI   = 5'h06;   // Upper five address bits 00110
    localparam logic [6:0] GEN_CALL_ADDR   = 7'h00;
    localparam logic [6:0] REG_PAGE_CTL    = 7'h00;
    localparam logic [6:0] REG_SOFT_RESET  = 7'h01;
    localparam logic [6:0] REG_RATE_DIV    = 7'h02;
    localparam logic [6:0] REG_BUS_DEBUG   = 7'h6B;   // Register 107 on page 0
    localparam logic [6:0] REG_LAST        = 7'h7F;
    localparam int         PAGE_BIT        = 0;
    localparam int         SRST_BIT        = 7;
    localparam int         DBG_STAT_BIT    = 0;
    localparam int         DBG_DIS_BIT     = 2;
    localparam logic [7:0] RATE_DIV_RST    = 8'h00;
    localparam logic [3:0] DAC_CODE_MAX    = 4'hA;    // Codes above are reserved
    localparam logic [3:0] ADC_CODE_MAX    = 4'hA;
    localparam logic [2:0] BIT_LAST        = 3'h7;
    localparam logic [7:0] BYTE_ZERO       = 8'h00;

    // Line events found by the sampler
    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
        logic sda;
    } line_evt_t;

    // Register write port toward the register file
    typedef struct packed {
        logic       en;
        logic [6:0] addr;
        logic [7:0] data;
    } reg_wr_t;
endpackage

// ### logic/line_sampler.sv
// Synchronises the two bus lines and finds clock edges, START and STOP.
// Assumes the lines are asynchronous to sys_clk_in and slow against it.
`timescale 1ns/1ps
`default_nettype none
module line_sampler
    import codec_ctl_pkg::*;
(
    // Clock and reset
    input  wire logic sys_clk_in,
    input  wire logic rstn_in,
    input  wire logic clk_en_in,
    // Bus lines
    input  wire logic scl_in,
    input  wire logic sda_in,
    // Events
    output line_evt_t evt_out
);
    logic [1:0] scl_sync_ff;
    logic [1:0] sda_sync_ff;
    logic       scl_prev_ff;
    logic       sda_prev_ff;

    // Two-stage synchronisers, then one history stage
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end else if (clk_en_in) begin
            scl_sync_ff <= {scl_sync_ff[0], scl_in};
            sda_sync_ff <= {sda_sync_ff[0], sda_in};
            scl_prev_ff <= scl_sync_ff[1];
            sda_prev_ff <= sda_sync_ff[1];
        end
    end

    // Data changes only under a high clock mark START and STOP
    assign evt_out.start    = scl_sync_ff[1] & scl_prev_ff & sda_prev_ff & ~sda_sync_ff[1];
    assign evt_out.stop     = scl_sync_ff[1] & scl_prev_ff & ~sda_prev_ff & sda_sync_ff[1];
    assign evt_out.scl_rise = scl_sync_ff[1] & ~scl_prev_ff;
    assign evt_out.scl_fall = ~scl_sync_ff[1] & scl_prev_ff;
    assign evt_out.sda      = sda_sync_ff[1];
endmodule
`default_nettype wire

// ### logic/paged_i2c_control_slave.sv
// Two-wire control slave with paged 8-bit registers.
// Assumes an external master drives the clock line; SDA is open drain.
// Summary of operation
// - Address is 00110 followed by strap pin 1 then strap pin 0.
// - Serves the two-wire protocol with 7-bit addressing when the select pin is low.
// - Acts only as slave; never makes START/STOP, never drives the clock.
// - Bytes of eight bits; send changes while clock low, sample on clock high.
// - Data fall under high clock is START, rise is STOP; STOP idles.
// - Pulls data low in the ninth clock to acknowledge each received byte, except a byte that sets the soft reset.
// - START during an active transfer restarts the address phase.
// - General call address zero is acknowledged too.
// - Further written bytes go to the next higher register, up to register 127.
// - Acknowledged read bytes are followed by the next higher register, up to register 127.
// - Bus-error detector on at reset; status reg 107 D0, D2 disables.
// - An enabled detector flags a STOP inside a byte in reg 107 D0.
// - Pages of 128 registers; address 0 is page control on every page.
// - Two pages; reset selects page 0; 1..127 use the selected page.
// - Page control bit D0 picks the page; upper bits reserved zero.
// - Every register is 8 bits, D7 most significant.
// - Writing 1 to register 1 bit D7 gives a self-clearing soft reset.
// - Register 2 D7..D4 is the ADC divider code, reset 0000.
// - Register 2 D3..D0 is the DAC divider code, reset 0000.
`timescale 1ns/1ps
`default_nettype none
module paged_i2c_control_slave
    import codec_ctl_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       rstn_in,
    input  wire logic       clk_en_in,
    // Bus pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    // Straps and protocol select
    input  wire logic       address_strap_pin0_in,
    input  wire logic       address_strap_pin1_in,
    input  wire logic       bus_select_in,
    // Register contents toward the codec
    output logic            page_sel_out,
    output logic [3:0]      adc_rate_code_out,
    output logic [3:0]      dac_rate_code_out,
    output logic            soft_reset_out,
    output logic            bus_error_out
);
    typedef enum {ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_RDATA, ST_ACK, ST_MACK, ST_IGNORE}
        state_t;

    line_evt_t  evt;
    state_t     state_ff;
    state_t     after_ack_ff;
    logic [7:0] shift_ff;
    logic [2:0] bit_ff;
    logic [6:0] ptr_ff;
    logic       page_ff;
    logic [7:0] rate_ff;
    logic       dbg_dis_ff;
    logic       err_ff;
    logic       srst_ff;
    logic       sda_low_ff;
    logic [1:0] straps_ff;
    logic [1:0] straps_s0_ff;
    logic       sel_s0_ff;
    logic       sel_ff;

    line_sampler i_line_sampler (
        .sys_clk_in (sys_clk_in),
        .rstn_in    (rstn_in),
        .clk_en_in  (clk_en_in),
        .scl_in     (scl_in),
        .sda_in     (sda_in),
        .evt_out    (evt)
    );

    // Next register address; no carry into another page
    function automatic logic [6:0] next_addr(input logic [6:0] a);
        next_addr = (a == REG_LAST) ? a : a + 7'h01;
    endfunction

    // Register read mux for the active page
    function automatic logic [7:0] reg_read(input logic [6:0] a, input logic pg,
                                            input logic [7:0] rt, input logic ds,
                                            input logic er);
        reg_read = BYTE_ZERO;
        if (a == REG_PAGE_CTL) begin
            reg_read[PAGE_BIT] = pg;
        end else if (!pg && a == REG_RATE_DIV) begin
            reg_read = rt;
        end else if (!pg && a == REG_BUS_DEBUG) begin
            reg_read[DBG_STAT_BIT] = er;
            reg_read[DBG_DIS_BIT]  = ds;
        end
    endfunction

    // Decodes
    wire        bus_on      = ~sel_ff;
    wire [6:0]  own_addr    = {ADDR_FIXED_HI, straps_ff};
    wire [7:0]  rx_byte     = {shift_ff[6:0], evt.sda};
    wire        addr_hit    = (rx_byte[7:1] == own_addr) ||
                              (rx_byte[7:1] == GEN_CALL_ADDR);
    wire        byte_done   = evt.scl_rise && (bit_ff == BIT_LAST);
    wire        active      = (state_ff != ST_IDLE);
    // A legal STOP comes after the first clock rise of a byte, so one counted bit is normal
    wire        glitch      = ~dbg_dis_ff && active && evt.stop && (bit_ff > 3'h1);
    wire [7:0]  rd_byte     = reg_read(ptr_ff, page_ff, rate_ff, dbg_dis_ff, err_ff);
    reg_wr_t    wr;
    assign wr.en   = (state_ff == ST_WDATA) && byte_done;
    assign wr.addr = ptr_ff;
    assign wr.data = rx_byte;

    // Straps and select pin pass two flip-flops
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            straps_s0_ff <= 2'h0;
            straps_ff    <= 2'h0;
            sel_s0_ff    <= 1'b1;
            sel_ff       <= 1'b1;
        end else if (clk_en_in) begin
            straps_s0_ff <= {address_strap_pin1_in, address_strap_pin0_in};
            straps_ff    <= straps_s0_ff;
            sel_s0_ff    <= bus_select_in;
            sel_ff       <= sel_s0_ff;
        end
    end

    // Protocol state machine
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_ff     <= ST_IDLE;
            after_ack_ff <= ST_IDLE;
            shift_ff     <= BYTE_ZERO;
            bit_ff       <= 3'h0;
            ptr_ff       <= REG_PAGE_CTL;
            sda_low_ff   <= 1'b0;
        end else if (clk_en_in) begin
            if (!bus_on || evt.stop || srst_ff) begin
                state_ff   <= ST_IDLE;
                sda_low_ff <= 1'b0;
            end else if (evt.start) begin
                state_ff   <= ST_ADDR;
                bit_ff     <= 3'h0;
                sda_low_ff <= 1'b0;
            end else begin
                case (state_ff)
                    ST_ADDR, ST_PTR, ST_WDATA: begin
                        if (evt.scl_rise) begin
                            shift_ff <= rx_byte;
                            bit_ff   <= bit_ff + 3'h1;
                        end
                        if (byte_done) begin
                            state_ff <= ST_ACK;
                            if (state_ff == ST_ADDR) begin
                                after_ack_ff <= !addr_hit ? ST_IGNORE :
                                                rx_byte[0] ? ST_RDATA : ST_PTR;
                            end else if (state_ff == ST_PTR) begin
                                ptr_ff       <= rx_byte[6:0];
                                after_ack_ff <= ST_WDATA;
                            end else begin
                                ptr_ff       <= next_addr(ptr_ff);
                                after_ack_ff <= ST_WDATA;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (evt.scl_fall) begin
                            if (sda_low_ff || after_ack_ff == ST_IGNORE) begin
                                state_ff   <= after_ack_ff;
                                shift_ff   <= rd_byte;
                                sda_low_ff <= (after_ack_ff == ST_RDATA) & ~rd_byte[7];
                            end else begin
                                sda_low_ff <= 1'b1;
                            end
                        end
                    end
                    ST_RDATA: begin
                        if (evt.scl_fall) begin
                            bit_ff <= bit_ff + 3'h1;
                            if (bit_ff == BIT_LAST) begin
                                state_ff   <= ST_MACK;
                                sda_low_ff <= 1'b0;
                                ptr_ff     <= next_addr(ptr_ff);
                            end else begin
                                sda_low_ff <= ~shift_ff[~bit_ff - 3'h1];
                            end
                        end
                    end
                    ST_MACK: begin
                        if (evt.scl_rise) begin
                            after_ack_ff <= evt.sda ? ST_IGNORE : ST_RDATA;
                        end
                        if (evt.scl_fall) begin
                            state_ff   <= after_ack_ff;
                            shift_ff   <= rd_byte;
                            sda_low_ff <= (after_ack_ff == ST_RDATA) & ~rd_byte[7];
                        end
                    end
                    ST_IGNORE: sda_low_ff <= 1'b0;
                    default:   state_ff   <= ST_IDLE;
                endcase
            end
        end
    end

    // Register file and error flag; soft reset clears them after one cycle
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            page_ff    <= 1'b0;
            rate_ff    <= RATE_DIV_RST;
            dbg_dis_ff <= 1'b0;
            err_ff     <= 1'b0;
            srst_ff    <= 1'b0;
        end else if (clk_en_in) begin
            srst_ff <= 1'b0;
            if (srst_ff) begin
                page_ff    <= 1'b0;
                rate_ff    <= RATE_DIV_RST;
                dbg_dis_ff <= 1'b0;
                err_ff     <= 1'b0;
            end else begin
                if (glitch) begin
                    err_ff <= 1'b1;
                end
                if (wr.en) begin
                    if (wr.addr == REG_PAGE_CTL) begin
                        page_ff <= wr.data[PAGE_BIT];
                    end else if (!page_ff && wr.addr == REG_SOFT_RESET) begin
                        srst_ff <= wr.data[SRST_BIT];
                    end else if (!page_ff && wr.addr == REG_RATE_DIV) begin
                        rate_ff <= wr.data;
                    end else if (!page_ff && wr.addr == REG_BUS_DEBUG) begin
                        dbg_dis_ff <= wr.data[DBG_DIS_BIT];
                        err_ff     <= glitch | (err_ff & wr.data[DBG_STAT_BIT]);
                    end
                end
            end
        end
    end

    // Outputs; the clock line is never driven
    assign sda_out           = 1'b0;
    assign sda_oe_out        = sda_low_ff;
    assign page_sel_out      = page_ff;
    assign adc_rate_code_out = rate_ff[7:4];
    assign dac_rate_code_out = rate_ff[3:0];
    assign soft_reset_out    = srst_ff;
    assign bus_error_out     = err_ff;

    // Checks
    a_ack_after_addr: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (clk_en_in && state_ff == ST_ACK && after_ack_ff == ST_PTR && evt.scl_fall && !evt.stop
         && !evt.start && !srst_ff && bus_on && !sda_low_ff) |=> sda_oe_out)
        else $error("no acknowledge after address");
    a_stop_idles: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (clk_en_in && evt.stop) |=> (state_ff == ST_IDLE && !sda_oe_out))
        else $error("stop did not idle");
    a_start_addr: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (clk_en_in && evt.start && !evt.stop && !srst_ff && bus_on) |=> state_ff == ST_ADDR)
        else $error("start did not begin address phase");
    a_srst_clears: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (clk_en_in && srst_ff) |=> (!srst_ff && !page_ff && rate_ff == RATE_DIV_RST))
        else $error("soft reset not self clearing");
    a_page_write: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (clk_en_in && wr.en && wr.addr == REG_PAGE_CTL && !srst_ff)
        |=> page_ff == $past(wr.data[PAGE_BIT]))
        else $error("page select not taken");
    a_err_flag: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (clk_en_in && glitch && !srst_ff) |=> err_ff)
        else $error("bus error not flagged");
    a_ptr_inc: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (clk_en_in && wr.en && ptr_ff != REG_LAST && !evt.start && !evt.stop && !srst_ff
         && bus_on) |=> ptr_ff == $past(ptr_ff) + 7'h01)
        else $error("pointer not advanced");
    a_no_foreign_ack: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        state_ff == ST_IGNORE |-> !sda_oe_out)
        else $error("foreign address acknowledged");
    c_write: cover property (@(posedge sys_clk_in) disable iff (!rstn_in) wr.en);
    c_read: cover property (@(posedge sys_clk_in) disable iff (!rstn_in) state_ff == ST_MACK);
    c_glitch: cover property (@(posedge sys_clk_in) disable iff (!rstn_in) glitch);
endmodule
`default_nettype wire

// ### tb/i2c_master_model.sv
// Two-wire bus master model: drives the clock and pulls the data line low.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
    // Clock
    input  wire logic       sys_clk_in,
    // Bus lines
    input  wire logic       sda_line_in,
    output logic            scl_out,
    output logic            sda_pull_out,
    // Byte results
    output logic            res_valid_out,
    output logic [7:0]      res_out
);
    // Idle bus: clock stands high, data released
    initial begin
        scl_out = 1'b1;
        sda_pull_out = 1'b0;
        res_valid_out = 1'b0;
        res_out = 8'h00;
    end
    // Quarter of a 160 ns bus period
    task automatic qtr();
        repeat (5) @(posedge sys_clk_in);
    endtask
    // START, or repeated START when the clock is low
    task automatic start();
        sda_pull_out <= 1'b0;
        qtr();
        scl_out <= 1'b1;
        qtr();
        sda_pull_out <= 1'b1;
        qtr();
        scl_out <= 1'b0;
        qtr();
    endtask
    // STOP leaves the bus idle
    task automatic stop();
        sda_pull_out <= 1'b1;
        qtr();
        scl_out <= 1'b1;
        qtr();
        sda_pull_out <= 1'b0;
        qtr();
    endtask
    // One bit: data set while the clock is low, sampled mid-high
    task automatic bit_io(input logic b, output logic s);
        sda_pull_out <= !b;
        qtr();
        scl_out <= 1'b1;
        qtr();
        s = sda_line_in;
        qtr();
        scl_out <= 1'b0;
        qtr();
    endtask
    // Hands one result to the bench for one cycle
    task automatic post(input logic [7:0] v);
        res_out <= v;
        res_valid_out <= 1'b1;
        @(posedge sys_clk_in);
        res_valid_out <= 1'b0;
    endtask
    // Sends a byte MSB first; result is 1 when acknowledged
    task automatic write_byte(input logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        post({7'h00, !s});
    endtask
    // Reads a byte, then acknowledges low or leaves the slot high
    task automatic read_byte(input logic ack);
        logic       s;
        logic [7:0] d;
        d = 8'h00;
        for (int i = 0; i < 8; i++) begin
            bit_io(1'b1, s);
            d = {d[6:0], s};
        end
        bit_io(!ack, s);
        post(d);
    endtask
endmodule
`default_nettype wire

// ### tb/paged_i2c_control_slave_bench.sv
// Bench for the paged two-wire control slave, driven by a master model.
// Assumes a pull-up on the data line and a clock line that only the master drives.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module paged_i2c_control_slave_bench
    import codec_ctl_pkg::*;
;
    logic       sys_clk_in, rstn_in, strap0, strap1, bus_sel, sda_out, sda_oe;
    logic       scl, sda_pull, page_sel, srst, bus_err, res_valid;
    logic [3:0] adc_code, dac_code;
    logic [7:0] res, v, v2;
    logic [8:0] e_now;
    logic [8:0] expq[$];
    logic [6:0] dev;
    logic [31:0] r;
    int         errors = 0, n_checks = 0, seed = 64237, srst_cnt = 0;
    wire        sda_line = !(sda_pull || (sda_oe && !sda_out));
    // Device and master
    paged_i2c_control_slave i_paged_i2c_control_slave (.sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in), .clk_en_in(1'b1), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_out(sda_oe), .address_strap_pin0_in(strap0),
        .address_strap_pin1_in(strap1), .bus_select_in(bus_sel), .page_sel_out(page_sel),
        .adc_rate_code_out(adc_code), .dac_rate_code_out(dac_code),
        .soft_reset_out(srst), .bus_error_out(bus_err));
    i2c_master_model i_i2c_master_model (.sys_clk_in(sys_clk_in), .sda_line_in(sda_line),
        .scl_out(scl), .sda_pull_out(sda_pull), .res_valid_out(res_valid), .res_out(res));
    // Clock, soft reset pulse count, oldest note against each result
    initial sys_clk_in = 1'b0;
    always #4 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) if (rstn_in && srst === 1'b1) srst_cnt++;
    always @(posedge sys_clk_in) begin
        if (res_valid) begin
            e_now = (expq.size() > 0) ? expq.pop_front() : 9'h000;
            if (!e_now[8]) `CHK("bus byte", e_now[7:0], res)
        end
    end
    task automatic complete_run();
        if (errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Byte out with expected acknowledge; dc skips the check
    task automatic send(input logic [7:0] d, input logic ack, input logic dc);
        expq.push_back({dc, 7'h00, ack});
        i_i2c_master_model.write_byte(d);
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d, input logic dc);
        i_i2c_master_model.start();
        send({dev, 1'b0}, 1'b1, 1'b0);
        send(ptr, 1'b1, 1'b0);
        send(d, 1'b1, dc);
        i_i2c_master_model.stop();
    endtask
    task automatic rd(input logic [7:0] ptr, input int n, input logic [23:0] e);
        i_i2c_master_model.start();
        send({dev, 1'b0}, 1'b1, 1'b0);
        send(ptr, 1'b1, 1'b0);
        i_i2c_master_model.start();
        send({dev, 1'b1}, 1'b1, 1'b0);
        for (int i = 0; i < n; i++) begin
            expq.push_back({1'b0, e[23 - 8 * i -: 8]});
            i_i2c_master_model.read_byte(i < n - 1);
        end
        i_i2c_master_model.stop();
    endtask
    // STOP after three address bits
    task automatic glitch();
        logic s;
        i_i2c_master_model.start();
        repeat (3) i_i2c_master_model.bit_io(1'b0, s);
        i_i2c_master_model.stop();
    endtask
    // Watchdog
    initial begin
        repeat (100000) @(posedge sys_clk_in);
        errors++;
        complete_run();
    end
    // Main sequence
    initial begin
        rstn_in = 1'b0;
        {strap1, strap0, bus_sel} = 3'h0;
        repeat (12) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        `CHK("page_sel_out", 1'b0, page_sel)
        `CHK("rate codes", 8'h00, {adc_code, dac_code})
        `CHK("bus_error_out", 1'b0, bus_err)
        for (int s = 0; s < 4; s++) begin
            {strap1, strap0} <= 2'(s);
            repeat (4) @(posedge sys_clk_in);
            dev = {ADDR_FIXED_HI, 2'(s)};
            i_i2c_master_model.start();
            send({ADDR_FIXED_HI, 2'(s ^ 1), 1'b0}, 1'b0, 1'b0);
            i_i2c_master_model.stop();
            r = $random(seed);
            v = {r[7:4] % 4'hA, r[3:0] % 4'hA}; // Codes stay legal after v ^ 11
            wr({1'b0, REG_RATE_DIV}, v, 1'b0);
            `CHK("rate codes", v, {adc_code, dac_code})
        end
        i_i2c_master_model.start();
        send(8'h00, 1'b1, 1'b0);
        i_i2c_master_model.stop();
        bus_sel <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        i_i2c_master_model.start();
        send({dev, 1'b0}, 1'b0, 1'b0);
        i_i2c_master_model.stop();
        bus_sel <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        `CHK("bus_error_out", 1'b0, bus_err)
        v2 = v ^ 8'h11;
        i_i2c_master_model.start();
        send({dev, 1'b0}, 1'b1, 1'b0);
        send({1'b0, REG_SOFT_RESET}, 1'b1, 1'b0);
        send(8'h00, 1'b1, 1'b0);
        send(v2, 1'b1, 1'b0);
        i_i2c_master_model.stop();
        `CHK("rate codes", v2, {adc_code, dac_code})
        `CHK("soft resets", 0, srst_cnt)
        rd(8'h00, 3, {8'h00, 8'h00, v2});
        wr(8'h00, 8'h01, 1'b0);
        `CHK("page_sel_out", 1'b1, page_sel)
        rd(8'h00, 1, 24'h010000);
        rd({1'b0, REG_RATE_DIV}, 1, 24'h000000);
        wr(8'h00, 8'h00, 1'b0);
        rd({1'b0, REG_RATE_DIV}, 1, {v2, 16'h0000});
        wr(8'h00, 8'h01, 1'b0);
        wr({1'b0, REG_SOFT_RESET}, 8'h80, 1'b0);
        `CHK("soft resets", 0, srst_cnt)
        wr(8'h00, 8'h00, 1'b0);
        wr({1'b0, REG_SOFT_RESET}, 8'h80, 1'b1);
        `CHK("soft resets", 1, srst_cnt)
        `CHK("page after soft reset", 1'b0, page_sel)
        `CHK("codes after soft reset", 8'h00, {adc_code, dac_code})
        wr({1'b0, REG_RATE_DIV}, v2, 1'b0);
        glitch();
        `CHK("bus_error_out", 1'b1, bus_err)
        wr({1'b0, REG_RATE_DIV}, v, 1'b0);
        `CHK("rate codes", v, {adc_code, dac_code})
        rd({1'b0, REG_BUS_DEBUG}, 1, 24'h010000);
        wr({1'b0, REG_BUS_DEBUG}, 8'h04, 1'b0);
        `CHK("bus_error_out", 1'b0, bus_err)
        glitch();
        `CHK("disabled detector", 1'b0, bus_err)
        complete_run();
    end
endmodule
`default_nettype wire
